/* File: core/addressable_port_switch.sv */
// Operation
// - Listen only in reset, idle and pause states.
// - Test-port state change aborts reception to start.
// - Pairs: idle HH, select LL, one LH, zero HL.
// - Frame is I, S, ten data, S, I.
// - Floating high input reads as idle.
// - Address assembled least significant bit first.
// - On frame end: no-match, off, then compare.
// - On match send acknowledge at once, then connect.
// - Acknowledge carries own address, LSB first.
// - No match: silent, exchange finished.
// - Errors before any address bit are ignored.
// - Sequencing error after data bits drops connection.
// - State change after data bits is hard error.
// - Over ten data bits, unless all ones or all zeros: hard error, off.
// - Long all ones syncs in pause; zeros reset.
// - Under ten data bits: hard error, off.
// - Low skip pin forces the connection.
// - Serial input sampled on rising link clock.
// - Acknowledge bits change on falling link clock.
// - 3FE disconnects; 3FF gives multicast status when received in a pause state.
// - Low test reset clears protocol state asynchronously.
`timescale 1ns/1ps
`default_nettype none
module addressable_port_switch (
   input  wire logic                sys_clk,
   input  wire logic                srst,
   input  wire logic                primary_test_clock,
   input  wire logic                primary_test_reset_n,
   input  wire logic                primary_mode_select,
   input  wire logic                primary_serial_in,
   output logic                     primary_serial_out,
   output logic                     primary_serial_out_en,
   input  wire logic [9:0]          board_address_inputs,
   input  wire logic                protocol_skip_pin_n,
   output asp_pkg::con_status_t     connect_status_q,
   output asp_pkg::result_t         protocol_result_q,
   output logic                     link_connected_q
);

   // Builds the acknowledge frame, first bit transmitted in the top position.
   function automatic logic [27:0] encode_frame(logic [9:0] a);
      logic [27:0] f;
      f = {asp_pkg::SYM_IDLE, asp_pkg::SYM_SEL, 20'h00000, asp_pkg::SYM_SEL, asp_pkg::SYM_IDLE};
      for (int i = 0; i < asp_pkg::ADDR_W; i++) begin
         f[23 - 2 * i -: 2] = a[i] ? asp_pkg::SYM_ONE : asp_pkg::SYM_ZERO;
      end
      encode_frame = f;
   endfunction

   function automatic logic is_pause(asp_pkg::tap_state_t s);
      is_pause = (s == asp_pkg::TAP_PDR) || (s == asp_pkg::TAP_PIR);
   endfunction

   // ---------------- Link domain ----------------
   asp_pkg::tap_state_t tap_q;
   asp_pkg::rx_state_t  rx_q, rx_d;
   asp_pkg::tap_state_t tap_ref_q, tap_ref_d;
   asp_pkg::link_stat_t stat_q, stat_d;
   logic                half_q, half_d;
   logic                b0_q, b0_d;
   logic [3:0]          cnt_q, cnt_d;
   logic [9:0]          addr_q, addr_d;
   logic                ones_q, ones_d;
   logic                zeros_q, zeros_d;
   logic                tgl_q;
   logic [9:0]          board_meta_q, board_q;
   logic [27:0]         tx_shift_q;
   logic [4:0]          tx_cnt_q;
   logic                tx_active_q;
   logic                tx_load, tx_done, frame_done, hard_err, stat_upd;

   tap_monitor u_tap (
      .clk     (primary_test_clock),
      .rst_n   (primary_test_reset_n),
      .tms     (primary_mode_select),
      .state_q (tap_q)
   );

   // Pair decode; the line is sampled on the rising edge only.
   // rising edge sampling
   wire logic [1:0] sym      = {b0_q, primary_serial_in};
   wire logic       sym_data = (sym == asp_pkg::SYM_ONE) || (sym == asp_pkg::SYM_ZERO);
   wire logic       tap_ok   = (tap_q == asp_pkg::TAP_TLR) || (tap_q == asp_pkg::TAP_RTI)
                               || is_pause(tap_q);
   wire logic       tap_moved = (tap_q != tap_ref_q);
   wire logic       addr_hit  = (addr_q == board_q);
   wire logic       ten_bits  = (cnt_q == asp_pkg::DATA_COUNT);
   wire logic       long_bits = (cnt_q > asp_pkg::DATA_COUNT);

   // The board address is a strap, brought into the link domain by two flops.
   always_ff @(posedge primary_test_clock or negedge primary_test_reset_n) begin
      if (!primary_test_reset_n) begin
         board_meta_q <= 10'h000;
         board_q      <= 10'h000;
      end else begin
         board_meta_q <= board_address_inputs;
         board_q      <= board_meta_q;
      end
   end

   // Receive sequencer. Alignment to pairs starts at the first low after idle.
   always_comb begin
      rx_d       = rx_q;
      tap_ref_d  = tap_ref_q;
      half_d     = ~half_q;
      b0_d       = b0_q;
      cnt_d      = cnt_q;
      addr_d     = addr_q;
      ones_d     = ones_q;
      zeros_d    = zeros_q;
      frame_done = 1'b0;
      hard_err   = 1'b0;
      tx_load    = 1'b0;
      if (rx_q == asp_pkg::RX_HUNT) begin
         half_d = 1'b0;
         if (tap_ok && !primary_serial_in) begin
            rx_d      = asp_pkg::RX_OPEN;
            half_d    = 1'b1;
            b0_d      = 1'b0;
            tap_ref_d = tap_q;
            cnt_d     = 4'h0;
            addr_d    = 10'h000;
            ones_d    = 1'b1;
            zeros_d   = 1'b1;
         end
      end else if (rx_q == asp_pkg::RX_ACK) begin
         half_d = 1'b0;
         if (tx_done) begin
            rx_d = asp_pkg::RX_HUNT;
         end
      end else if (tap_moved) begin
         rx_d   = asp_pkg::RX_HUNT;
         half_d = 1'b0;
         hard_err = (cnt_q != 4'h0);
      end else if (!half_q) begin
         b0_d = primary_serial_in;
      end else begin
         case (rx_q)
            asp_pkg::RX_OPEN: begin
               rx_d = (sym == asp_pkg::SYM_SEL) ? asp_pkg::RX_LEAD : asp_pkg::RX_SOFT;
               if (sym == asp_pkg::SYM_IDLE) begin
                  rx_d = asp_pkg::RX_HUNT;
               end
            end
            asp_pkg::RX_LEAD, asp_pkg::RX_DATA: begin
               if (sym_data) begin
                  rx_d = asp_pkg::RX_DATA;
                  // first bit lands in bit zero
                  if (cnt_q < asp_pkg::DATA_COUNT) begin
                     addr_d[cnt_q] = primary_serial_in;
                  end
                  cnt_d   = (cnt_q == asp_pkg::DATA_SAT) ? cnt_q : cnt_q + 4'h1;
                  ones_d  = ones_q & primary_serial_in;
                  zeros_d = zeros_q & ~primary_serial_in;
               end else if (rx_q == asp_pkg::RX_LEAD) begin
                  rx_d = (sym == asp_pkg::SYM_IDLE) ? asp_pkg::RX_HUNT : asp_pkg::RX_SOFT;
               end else if (sym == asp_pkg::SYM_SEL) begin
                  rx_d = asp_pkg::RX_TRAIL;
               end else begin
                  hard_err = 1'b1;
                  rx_d     = asp_pkg::RX_HUNT;
               end
            end
            asp_pkg::RX_TRAIL: begin
               if (sym == asp_pkg::SYM_IDLE) begin
                  frame_done = 1'b1;
                  rx_d       = asp_pkg::RX_HUNT;
                  if (ten_bits && addr_hit && (addr_q != asp_pkg::RESET_ADDR)
                      && (addr_q != asp_pkg::DISC_ADDR) && (addr_q != asp_pkg::SYNC_ADDR)) begin
                     tx_load = 1'b1;
                     rx_d    = asp_pkg::RX_ACK;
                  end
               end else begin
                  hard_err = 1'b1;
                  rx_d     = asp_pkg::RX_SOFT;
               end
            end
            asp_pkg::RX_SOFT: begin
               if (sym == asp_pkg::SYM_IDLE) begin
                  rx_d = asp_pkg::RX_HUNT;
               end
            end
            default: rx_d = asp_pkg::RX_HUNT;
         endcase
      end
   end

   // Result of a completed frame or an error, or connect when the acknowledge ends; otherwise the status holds.
   always_comb begin
      stat_d   = stat_q;
      stat_upd = 1'b0;
      if (hard_err) begin
         stat_d   = '{status: asp_pkg::CON_OFF, result: asp_pkg::RES_ERROR};
         stat_upd = 1'b1;
      end else if (frame_done) begin
         stat_d   = '{status: asp_pkg::CON_OFF, result: asp_pkg::RES_NOMATCH};
         stat_upd = 1'b1;
         if ((ten_bits || long_bits) && zeros_q) begin
            stat_d = '{status: asp_pkg::CON_RESET, result: asp_pkg::RES_RESET};
         end else if ((ten_bits || long_bits) && ones_q) begin
            if (is_pause(tap_ref_q)) begin
               stat_d = '{status: asp_pkg::CON_MULTICAST, result: asp_pkg::RES_SYNC};
            end
         end else if (!ten_bits) begin
            stat_d.result = asp_pkg::RES_ERROR;
         end else if (addr_q == asp_pkg::DISC_ADDR) begin
            stat_d.result = asp_pkg::RES_DISCONNECT;
         end else if (addr_hit) begin
            stat_d.result = asp_pkg::RES_MATCH;
         end
      end else if (tx_done) begin
         stat_d.status = asp_pkg::CON_ON;
         stat_upd      = 1'b1;
      end
   end

   always_ff @(posedge primary_test_clock or negedge primary_test_reset_n) begin
      if (!primary_test_reset_n) begin
         rx_q      <= asp_pkg::RX_HUNT;
         tap_ref_q <= asp_pkg::TAP_TLR;
         half_q    <= 1'b0;
         b0_q      <= 1'b1;
         cnt_q     <= 4'h0;
         addr_q    <= 10'h000;
         ones_q    <= 1'b1;
         zeros_q   <= 1'b1;
      end else begin
         rx_q      <= rx_d;
         tap_ref_q <= tap_ref_d;
         half_q    <= half_d;
         b0_q      <= b0_d;
         cnt_q     <= cnt_d;
         addr_q    <= addr_d;
         ones_q    <= ones_d;
         zeros_q   <= zeros_d;
      end
   end

   always_ff @(posedge primary_test_clock or negedge primary_test_reset_n) begin
      if (!primary_test_reset_n) begin
         stat_q <= asp_pkg::POWERUP_STAT;
         tgl_q  <= 1'b0;
      end else begin
         stat_q <= stat_d;
         tgl_q  <= tgl_q ^ stat_upd;
      end
   end

   assign tx_done = tx_active_q && (tx_cnt_q == asp_pkg::FRAME_LAST);

   always_ff @(posedge primary_test_clock or negedge primary_test_reset_n) begin
      if (!primary_test_reset_n) begin
         tx_shift_q  <= 28'h0000000;
         tx_cnt_q    <= 5'h00;
         tx_active_q <= 1'b0;
      end else if (tx_load) begin
         tx_shift_q  <= encode_frame(board_q);
         tx_cnt_q    <= 5'h00;
         tx_active_q <= 1'b1;
      end else if (tx_active_q) begin
         tx_shift_q  <= {tx_shift_q[26:0], 1'b1};
         tx_cnt_q    <= tx_cnt_q + 5'h01;
         tx_active_q <= !tx_done;
      end
   end

   always_ff @(negedge primary_test_clock or negedge primary_test_reset_n) begin
      if (!primary_test_reset_n) begin
         primary_serial_out    <= 1'b1;
         primary_serial_out_en <= 1'b0;
      end else begin
         primary_serial_out    <= tx_active_q ? tx_shift_q[asp_pkg::FRAME_BITS-1] : 1'b1;
         primary_serial_out_en <= tx_active_q;
      end
   end

   // ---------------- System clock domain ----------------
   // Status words are stable whenever the toggle moves; a change needs at least a select and a data pair,
   // so the words can be captured once the toggle has crossed.
   logic [2:0] sync_q;
   logic       tgl_seen_q;

   bit_sync #(.W(3), .RST_VAL(3'h7)) u_sync (
      .clk (sys_clk),
      .rst (srst),
      .d   ({protocol_skip_pin_n, primary_test_reset_n, tgl_q}),
      .q   (sync_q)
   );

   wire logic skip_s     = sync_q[2];
   wire logic trst_s     = sync_q[1];
   wire logic stat_event = sync_q[0] ^ tgl_seen_q;

   // Capture crossed status; a held test reset shows as off.
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         tgl_seen_q        <= 1'b1;
         connect_status_q  <= asp_pkg::CON_OFF;
         protocol_result_q <= asp_pkg::RES_NONE;
         link_connected_q  <= 1'b0;
      end else begin
         tgl_seen_q        <= sync_q[0];
         connect_status_q  <= !trst_s ? asp_pkg::CON_OFF
                              : (stat_event ? stat_q.status : connect_status_q);
         protocol_result_q <= !trst_s ? asp_pkg::RES_NONE
                              : (stat_event ? stat_q.result : protocol_result_q);
         link_connected_q  <= !skip_s || (trst_s && (connect_status_q == asp_pkg::CON_ON));
      end
   end

   // ---------------- Checks ----------------
   ack_only_match_a: assert property (
      @(posedge primary_test_clock) disable iff (!primary_test_reset_n)
      tx_load |=> stat_q.result == asp_pkg::RES_MATCH && stat_q.status == asp_pkg::CON_OFF)
      else $error("Acknowledge started without a match.");
   ack_length_a: assert property (
      @(posedge primary_test_clock) disable iff (!primary_test_reset_n)
      tx_load |=> tx_active_q ##27 (tx_active_q && tx_done) ##1 !tx_active_q)
      else $error("Acknowledge frame has wrong length.");
   connect_after_ack_a: assert property (
      @(posedge primary_test_clock) disable iff (!primary_test_reset_n)
      $fell(tx_active_q) |-> stat_q.status == asp_pkg::CON_ON)
      else $error("No connection after acknowledge.");
   hard_err_off_a: assert property (
      @(posedge primary_test_clock) disable iff (!primary_test_reset_n)
      hard_err |=> stat_q.status == asp_pkg::CON_OFF && stat_q.result == asp_pkg::RES_ERROR)
      else $error("Hard error left a connection.");
   short_addr_a: assert property (
      @(posedge primary_test_clock) disable iff (!primary_test_reset_n)
      frame_done && cnt_q < asp_pkg::DATA_COUNT |=> stat_q.status == asp_pkg::CON_OFF)
      else $error("Short address did not turn off.");
   abort_tap_a: assert property (
      @(posedge primary_test_clock) disable iff (!primary_test_reset_n)
      rx_q inside {asp_pkg::RX_OPEN, asp_pkg::RX_LEAD, asp_pkg::RX_DATA} && tap_moved
      |=> rx_q == asp_pkg::RX_HUNT)
      else $error("State change did not abort reception.");
   status_hold_a: assert property (
      @(posedge primary_test_clock) disable iff (!primary_test_reset_n)
      !frame_done && !hard_err && !tx_done |=> $stable(stat_q))
      else $error("Status changed without cause.");
   ack_preamble_a: assert property (
      @(negedge primary_test_clock) disable iff (!primary_test_reset_n)
      $rose(primary_serial_out_en) |-> primary_serial_out ##1 primary_serial_out
      ##1 !primary_serial_out ##1 !primary_serial_out)
      else $error("Acknowledge does not open with idle and select.");
   no_listen_shift_a: assert property (
      @(posedge primary_test_clock) disable iff (!primary_test_reset_n)
      rx_q == asp_pkg::RX_HUNT && !tap_ok |=> rx_q == asp_pkg::RX_HUNT)
      else $error("Reception started in a shift state.");
   bypass_force_a: assert property (
      @(posedge sys_clk) disable iff (srst)
      !skip_s |=> link_connected_q)
      else $error("Skip pin did not force connection.");

   match_seen_c: cover property (@(posedge primary_test_clock) $fell(tx_active_q));
   hard_seen_c:  cover property (@(posedge primary_test_clock) hard_err);
   sync_seen_c:  cover property (@(posedge primary_test_clock)
                                 stat_q.status == asp_pkg::CON_MULTICAST);
   skip_seen_c:  cover property (@(posedge sys_clk) !skip_s && link_connected_q);

endmodule
`default_nettype wire

/* File: core/bit_sync.sv */
`timescale 1ns/1ps
`default_nettype none
module bit_sync #(
   parameter int         W       = 1,
   parameter logic [W-1:0] RST_VAL = '0
) (
   input  wire logic         clk,
   input  wire logic         rst,
   input  wire logic [W-1:0] d,
   output logic      [W-1:0] q
);

   logic [W-1:0] meta_q;

   // Two flops; only the second stage is visible to any logic.
   always_ff @(posedge clk) begin
      if (rst) begin
         meta_q <= RST_VAL;
         q      <= RST_VAL;
      end else begin
         meta_q <= d;
         q      <= meta_q;
      end
   end

endmodule
`default_nettype wire

/* File: core/tap_monitor.sv */
`timescale 1ns/1ps
`default_nettype none
module tap_monitor (
   input  wire logic                clk,
   input  wire logic                rst_n,
   input  wire logic                tms,
   output asp_pkg::tap_state_t      state_q
);

   // Standard test-port state table, advanced on the mode line.
   function automatic asp_pkg::tap_state_t next_state(asp_pkg::tap_state_t s, logic m);
      case (s)
         asp_pkg::TAP_TLR:   next_state = m ? asp_pkg::TAP_TLR   : asp_pkg::TAP_RTI;
         asp_pkg::TAP_RTI:   next_state = m ? asp_pkg::TAP_SELDR : asp_pkg::TAP_RTI;
         asp_pkg::TAP_SELDR: next_state = m ? asp_pkg::TAP_SELIR : asp_pkg::TAP_CAPDR;
         asp_pkg::TAP_CAPDR: next_state = m ? asp_pkg::TAP_EX1DR : asp_pkg::TAP_SHDR;
         asp_pkg::TAP_SHDR:  next_state = m ? asp_pkg::TAP_EX1DR : asp_pkg::TAP_SHDR;
         asp_pkg::TAP_EX1DR: next_state = m ? asp_pkg::TAP_UPDR  : asp_pkg::TAP_PDR;
         asp_pkg::TAP_PDR:   next_state = m ? asp_pkg::TAP_EX2DR : asp_pkg::TAP_PDR;
         asp_pkg::TAP_EX2DR: next_state = m ? asp_pkg::TAP_UPDR  : asp_pkg::TAP_SHDR;
         asp_pkg::TAP_UPDR:  next_state = m ? asp_pkg::TAP_SELDR : asp_pkg::TAP_RTI;
         asp_pkg::TAP_SELIR: next_state = m ? asp_pkg::TAP_TLR   : asp_pkg::TAP_CAPIR;
         asp_pkg::TAP_CAPIR: next_state = m ? asp_pkg::TAP_EX1IR : asp_pkg::TAP_SHIR;
         asp_pkg::TAP_SHIR:  next_state = m ? asp_pkg::TAP_EX1IR : asp_pkg::TAP_SHIR;
         asp_pkg::TAP_EX1IR: next_state = m ? asp_pkg::TAP_UPIR  : asp_pkg::TAP_PIR;
         asp_pkg::TAP_PIR:   next_state = m ? asp_pkg::TAP_EX2IR : asp_pkg::TAP_PIR;
         asp_pkg::TAP_EX2IR: next_state = m ? asp_pkg::TAP_UPIR  : asp_pkg::TAP_SHIR;
         asp_pkg::TAP_UPIR:  next_state = m ? asp_pkg::TAP_SELDR : asp_pkg::TAP_RTI;
         default:            next_state = asp_pkg::TAP_TLR;
      endcase
   endfunction

   // Powers up in Test-Logic-Reset; the test reset forces it there at once.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state_q <= asp_pkg::TAP_TLR;
      end else begin
         state_q <= next_state(state_q, tms);
      end
   end

endmodule
`default_nettype wire

/* File: dv/addressable_scan_shadow_protocol_bench.sv */
`timescale 1ns/1ps
`default_nettype none
module addressable_scan_shadow_protocol_bench;
   logic                 sys_clk, srst, trst_n, skip_n;
   logic [9:0]           board;
   wire                  tck, tdi, tms, tdo, tdo_en;
   asp_pkg::con_status_t stat;
   asp_pkg::result_t     res;
   logic                 conn;
   logic [15:0]          pick [5];
   logic [15:0]          a;
   int                   errors, tests_run, cyc;
   int                   n_tab [10] = '{10, 5, 10, 10, 10, 10, 12, 10, 11, 12};
   int                   k_tab [10] = '{0, 0, 0, 1, 0, 2, 3, 0, 0, 4};
   asp_pkg::link_stat_t  e;

   scan_master_model i_master (.tck(tck), .tdi(tdi), .tms(tms), .tdo(tdo), .tdo_en(tdo_en));

   addressable_port_switch i_dut (
      .sys_clk(sys_clk), .srst(srst), .primary_test_clock(tck),
      .primary_test_reset_n(trst_n), .primary_mode_select(tms), .primary_serial_in(tdi),
      .primary_serial_out(tdo), .primary_serial_out_en(tdo_en),
      .board_address_inputs(board), .protocol_skip_pin_n(skip_n),
      .connect_status_q(stat), .protocol_result_q(res), .link_connected_q(conn));

   always #12.5 sys_clk = ~sys_clk;

   // Guard against a hang; the whole run needs well under 3000 cycles.
   always @(posedge sys_clk) begin
      cyc++;
      if (cyc == 8000) begin
         errors++;
         conclude();
      end
   end

   // Reference outcome of one frame; global addresses win over the strap.
   function automatic asp_pkg::link_stat_t model(input int n, input int v, input bit p);
      model = '{asp_pkg::CON_OFF, asp_pkg::RES_ERROR};
      if (n < 10) return model;
      if (v == 0) model = '{asp_pkg::CON_RESET, asp_pkg::RES_RESET};
      else if (v == (1 << n) - 1) begin
         model = '{asp_pkg::CON_OFF, asp_pkg::RES_NOMATCH};
         if (p) model = '{asp_pkg::CON_MULTICAST, asp_pkg::RES_SYNC};
      end
      else if (n > 10) return model;
      else if (v == asp_pkg::DISC_ADDR) model = '{asp_pkg::CON_OFF, asp_pkg::RES_DISCONNECT};
      else if (v == board) model = '{asp_pkg::CON_ON, asp_pkg::RES_MATCH};
      else model = '{asp_pkg::CON_OFF, asp_pkg::RES_NOMATCH};
   endfunction

   task automatic cmp(input asp_pkg::link_stat_t x, input logic c);
      tests_run++;
      if ({stat, res, conn} !== {x, c}) begin
         errors++;
         $display("unexpected at %0t: status %0d result %0d conn %b", $time, stat, res, conn);
      end
   endtask

   // Expected echo: idle, select, own address LSB first, select, idle.
   task automatic cmp_ack(input logic m, input logic [9:0] v);
      logic [31:0] x;
      x = 32'hC;
      for (int i = 0; i < 10; i++) x = {x[29:0], ~v[i], v[i]};
      x = {x[27:0], 4'h3};
      tests_run++;
      if ((m ? 28 : 0) != i_master.ack_n || (m && x !== i_master.ack_v)) begin
         errors++;
         $display("unexpected at %0t: acknowledge %0d bits %h", $time, i_master.ack_n,
                  i_master.ack_v);
      end
   endtask

   task automatic conclude;
      $display("errors %0d tests_run %0d", errors, tests_run);
      if (errors == 0 && tests_run > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask

   initial begin
      sys_clk = 1'b0;
      srst = 1'b1;
      trst_n = 1'b0;
      skip_n = 1'b1;
      errors = 0;
      tests_run = 0;
      cyc = 0;
      void'($urandom(10193));
      // strap kept clear of the global addresses
      board = 10'h100 + 10'($urandom % 512);
      pick = '{16'(board), 16'(board ^ 10'h1), 16'(asp_pkg::DISC_ADDR), 16'h0, 16'hFFFF};
      repeat (2) @(posedge sys_clk);
      @(negedge sys_clk);
      srst = 1'b0;
      trst_n = 1'b1;
      repeat (4) @(posedge tck);
      for (int i = 0; i < 10; i++) begin
         // Last frame is sent from the paused data scan.
         if (i == 9) for (int j = 5; j >= 0; j--) i_master.walk(1'(6'b010010 >> j));
         a = pick[k_tab[i]] & 16'((1 << n_tab[i]) - 1);
         i_master.frame(n_tab[i], a);
         repeat (36) @(posedge tck);
         @(negedge sys_clk);
         e = model(n_tab[i], int'(a), i == 9);
         cmp(e, e.status == asp_pkg::CON_ON);
         cmp_ack(e.result == asp_pkg::RES_MATCH, a[9:0]);
      end
      // Each error case follows a fresh match: a lone data run is a soft error and keeps the
      // connection; data then idle, or a deliberate mode-line change after data, drops it.
      for (int i = 0; i < 3; i++) begin
         i_master.frame(10, 16'(board));
         repeat (36) @(posedge tck);
         @(negedge sys_clk);
         cmp('{asp_pkg::CON_ON, asp_pkg::RES_MATCH}, 1'b1);
         i_master.sym(asp_pkg::SYM_IDLE);
         if (i > 0) i_master.sym(asp_pkg::SYM_SEL);
         repeat (3) i_master.sym(asp_pkg::SYM_ONE);
         if (i == 2) i_master.walk(1'b1);
         i_master.sym(asp_pkg::SYM_IDLE);
         repeat (12) @(posedge tck);
         @(negedge sys_clk);
         e = '{asp_pkg::CON_OFF, asp_pkg::RES_ERROR};
         if (i == 0) e = '{asp_pkg::CON_ON, asp_pkg::RES_MATCH};
         cmp(e, i == 0);
      end
      skip_n = 1'b0;
      repeat (4) @(negedge sys_clk);
      cmp(e, 1'b1);
      trst_n = 1'b0;
      repeat (5) @(negedge sys_clk);
      cmp('{asp_pkg::CON_OFF, asp_pkg::RES_NONE}, 1'b1);
      conclude();
   end
endmodule
`default_nettype wire

/* File: dv/scan_master_model.sv */
`timescale 1ns/1ps
`default_nettype none
module scan_master_model (
   output logic      tck,
   output logic      tdi,
   output logic      tms,
   input  wire logic tdo,
   input  wire logic tdo_en
);
   logic [31:0] ack_v;
   int          ack_n;

   // The test clock runs free, as a bus master's clock does; 48 ns period.
   initial begin
      tck = 1'b0;
      tdi = 1'b1;
      tms = 1'b1;
      ack_v = 32'h0;
      ack_n = 0;
      forever #24 tck = ~tck;
   end

   // Acknowledge bits are taken at the rising edge, half a cycle after they change.
   always @(posedge tck) begin
      if (tdo_en === 1'b1) begin
         ack_v = {ack_v[30:0], tdo};
         ack_n++;
      end
   end

   task automatic put(input logic b);
      @(negedge tck);
      tdi = b;
   endtask

   task automatic walk(input logic b);
      @(negedge tck);
      tms = b;
   endtask

   task automatic sym(input logic [1:0] p);
      put(p[1]);
      put(p[0]);
   endtask

   // frame, LSB first, mode line untouched; the line is left high as idle.
   task automatic frame(input int n, input logic [15:0] a);
      ack_v = 32'h0;
      ack_n = 0;
      sym(asp_pkg::SYM_IDLE);
      sym(asp_pkg::SYM_SEL);
      for (int i = 0; i < n; i++) begin
         sym(a[i] ? asp_pkg::SYM_ONE : asp_pkg::SYM_ZERO);
      end
      sym(asp_pkg::SYM_SEL);
      sym(asp_pkg::SYM_IDLE);
   endtask
endmodule
`default_nettype wire

/* File: include/asp_pkg.sv */
package asp_pkg;

   // Address width and the three global addresses.
   localparam int          ADDR_W     = 10;
   localparam logic [9:0]  RESET_ADDR = 10'h000;
   localparam logic [9:0]  DISC_ADDR  = 10'h3FE;
   localparam logic [9:0]  SYNC_ADDR  = 10'h3FF;

   // Bit-pair codes, first bit in the upper position.
   localparam logic [1:0]  SYM_IDLE   = 2'h3;
   localparam logic [1:0]  SYM_SEL    = 2'h0;
   localparam logic [1:0]  SYM_ONE    = 2'h1;
   localparam logic [1:0]  SYM_ZERO   = 2'h2;

   // An acknowledge frame is fourteen pairs: I, S, ten data, S, I.
   localparam int          FRAME_BITS = 28;
   localparam logic [4:0]  FRAME_LAST = 5'h1B;
   localparam logic [3:0]  DATA_COUNT = 4'hA;
   localparam logic [3:0]  DATA_SAT   = 4'hF;

   typedef enum logic [3:0] {
      TAP_TLR, TAP_RTI, TAP_SELDR, TAP_CAPDR, TAP_SHDR, TAP_EX1DR, TAP_PDR, TAP_EX2DR,
      TAP_UPDR, TAP_SELIR, TAP_CAPIR, TAP_SHIR, TAP_EX1IR, TAP_PIR, TAP_EX2IR, TAP_UPIR
   } tap_state_t;

   typedef enum logic [2:0] {
      RX_HUNT, RX_OPEN, RX_LEAD, RX_DATA, RX_TRAIL, RX_SOFT, RX_ACK
   } rx_state_t;

   typedef enum logic [1:0] {CON_OFF, CON_ON, CON_MULTICAST, CON_RESET} con_status_t;

   typedef enum logic [2:0] {
      RES_NONE, RES_NOMATCH, RES_MATCH, RES_DISCONNECT, RES_SYNC, RES_RESET, RES_ERROR
   } result_t;

   // Connect status and protocol result travel together across domains.
   typedef struct packed {
      con_status_t status;
      result_t     result;
   } link_stat_t;

   localparam link_stat_t POWERUP_STAT = '{status: CON_OFF, result: RES_NONE};

endpackage
